// ### common/u3mt_pkg.sv
package u3mt_pkg;

  // -----------------------------------------------------------------
  // Sizes
  // -----------------------------------------------------------------
  localparam int NS  = 8;
  localparam int NU  = 6;
  localparam int NDU = 4;
  localparam int U_EV  = 4;
  localparam int U_TMR = 5;

  // -----------------------------------------------------------------
  // Packet categories
  // -----------------------------------------------------------------
  localparam logic [2:0] CAT_LC  = 3'h0;
  localparam logic [2:0] CAT_HP  = 3'h1;
  localparam logic [2:0] CAT_DP  = 3'h2;
  localparam logic [2:0] CAT_QDP = 3'h3;
  localparam logic [2:0] CAT_TS  = 3'h4;

  localparam logic [1:0] CRC_ANY = 2'h0;
  localparam logic [1:0] CRC_OK  = 2'h1;
  localparam logic [1:0] CRC_BAD = 2'h2;

  // -----------------------------------------------------------------
  // Register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STAT   = 8'h04;
  localparam logic [7:0] A_SEL    = 8'h08;
  localparam logic [7:0] A_CFG0   = 8'h10;
  localparam logic [7:0] A_CFG1   = 8'h14;
  localparam logic [7:0] A_CFG2   = 8'h18;
  localparam logic [7:0] A_CFG3   = 8'h1c;
  localparam logic [7:0] A_MEMLIM = 8'h20;
  localparam logic [7:0] A_PRELIM = 8'h24;
  localparam logic [7:0] A_OCC    = 8'h28;
  localparam logic [7:0] A_STORED = 8'h2c;

  localparam logic [31:0] MEMLIM_RST = 32'h0400_0000;
  localparam logic [31:0] PRELIM_RST = 32'h0000_0000;
  localparam logic [31:0] BUF_WORDS  = 32'h2000_0000;

  typedef enum logic [1:0] { U3MT_MODE_SS = 2'h0, U3MT_MODE_HS = 2'h1,
                             U3MT_MODE_BOTH = 2'h2 } u3mt_mode_t;

  // Observed SuperSpeed packet, one per pkt_valid cycle.
  typedef struct packed {
    logic        dir;
    logic [2:0]  cat;
    logic [7:0]  sub;
    logic        crc_ok;
    logic [6:0]  addr;
    logic [3:0]  ep;
    logic [15:0] strm;
    logic [11:0] len;
    logic [31:0] data;
  } u3mt_pkt_t;

  // Link events per direction: lfps, polarity, termination, scramble off.
  typedef struct packed {
    logic [3:0] up;
    logic [3:0] dn;
  } u3mt_ev_t;

endpackage

// ### hdl/u3mt_trigger.sv
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Data unit picks a direction and one of five packet categories.
// - A unit can narrow a category to one subtype.
// - Each data unit can demand a good or a bad CRC.
// - Inverted criterion matches same-category packets other than the subtype.
// - Cross-category option makes the inversion match any other packet.
// - Data packets compare payload; category QDP also optionally compares address, stream, endpoint, length.
// - Event unit sees LFPS, polarity, termination, scramble-off in both directions.
// - Event unit also sees bus supply detect and external input edges.
// - Timer unit starts on state entry and matches after programmed interval.
// - Actions run only once the programmed match count is reached.
// - Optional repeat: act on every match after the count.
// - Actions: trigger, external output, filter data, change state.
// - State change only with advanced mode, else single state.
// - Each unit in each state has its own action setting.
// - Full buffer stops storing while upload keeps draining.
// - Software limits capture memory below the installed size.
// - Capture memory splits into pre-trigger and post-trigger parts.
// - Captured data streams out continuously during capture.
// - Capture SuperSpeed, USB 2.0, or both when upgrade enabled.
// - Infinite capture removes the size limit.
// - USB 2.0 matcher hits and input rising edges may trigger capture.
// - Up to eight states of match units.
// - Lowest-numbered firing unit with goto set decides the next state.
// - Capture triggers once; later trigger matches are ignored.
module u3mt_trigger (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              pkt_valid,
  input  wire u3mt_pkg::u3mt_pkt_t pkt,
  input  wire u3mt_pkg::u3mt_ev_t  ev,
  input  wire logic              u2_valid,
  input  wire logic              u2_hit,
  input  wire logic              vbus_pin,
  input  wire logic              ext_in_pin,
  input  wire logic              upl_ready,
  output logic                   upl_valid,
  output logic                   store_ss,
  output logic                   store_u2,
  output logic                   pre_drop,
  output logic                   filt,
  output logic                   trig_pulse,
  output logic                   ext_out,
  output logic [2:0]             cur_state
);

  // -----------------------------------------------------------------
  // Pin synchronisers and edges
  // -----------------------------------------------------------------
  logic [1:0] vbus_sync_q;
  logic [1:0] ext_sync_q;
  logic       vbus_prev_q;
  logic       ext_prev_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      vbus_sync_q <= 2'h0;
      ext_sync_q  <= 2'h0;
      vbus_prev_q <= 1'b0;
      ext_prev_q  <= 1'b0;
    end
    else
    begin
      vbus_sync_q <= {vbus_sync_q[0], vbus_pin};
      ext_sync_q  <= {ext_sync_q[0], ext_in_pin};
      vbus_prev_q <= vbus_sync_q[1];
      ext_prev_q  <= ext_sync_q[1];
    end
  end

  wire vbus_rise = vbus_sync_q[1] & ~vbus_prev_q;
  wire ext_rise  = ext_sync_q[1] & ~ext_prev_q;
  wire ext_fall  = ~ext_sync_q[1] & ext_prev_q;
  // Event vector order: 8 link events, supply detect, input rise, input fall.
  wire [10:0] ev_vec = {ext_fall, ext_rise, vbus_rise, ev.dn, ev.up};

  // -----------------------------------------------------------------
  // AHB-Lite slave
  // -----------------------------------------------------------------
  logic       dp_wr_q;
  logic       dp_rd_q;
  logic [7:0] dp_addr_q;
  wire        ap_take = hsel & hready & htrans[1];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end
    else if (hready)
    begin
      dp_wr_q   <= ap_take & hwrite;
      dp_rd_q   <= ap_take & ~hwrite;
      dp_addr_q <= haddr[7:0];
    end
  end

  // Every transfer finishes in its first data-phase cycle.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire wr_ctrl   = dp_wr_q & (dp_addr_q == u3mt_pkg::A_CTRL);
  wire wr_sel    = dp_wr_q & (dp_addr_q == u3mt_pkg::A_SEL);
  wire wr_cfg0   = dp_wr_q & (dp_addr_q == u3mt_pkg::A_CFG0);
  wire wr_cfg1   = dp_wr_q & (dp_addr_q == u3mt_pkg::A_CFG1);
  wire wr_cfg2   = dp_wr_q & (dp_addr_q == u3mt_pkg::A_CFG2);
  wire wr_cfg3   = dp_wr_q & (dp_addr_q == u3mt_pkg::A_CFG3);
  wire wr_memlim = dp_wr_q & (dp_addr_q == u3mt_pkg::A_MEMLIM);
  wire wr_prelim = dp_wr_q & (dp_addr_q == u3mt_pkg::A_PRELIM);

  // -----------------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------------
  // CTRL: 0 start, 1 stop, 2 advanced, 3 infinite, 5:4 mode, 6 upgrade,
  // 7 USB 2.0 hit trigger enable.
  logic        adv_q;
  logic        inf_q;
  logic [1:0]  mode_q;
  logic        upg_q;
  logic        u2trg_q;
  logic [5:0]  sel_q;
  logic [31:0] memlim_q;
  logic [31:0] prelim_q;
  logic [31:0] cfg0_q [0:63];
  logic [31:0] cfg1_q [0:63];
  logic [31:0] cfg2_q [0:63];
  logic [31:0] cfg3_q [0:63];

  wire start = wr_ctrl & hwdata[0];
  wire stop  = wr_ctrl & hwdata[1];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      adv_q    <= 1'b0;
      inf_q    <= 1'b0;
      mode_q   <= 2'h0;
      upg_q    <= 1'b0;
      u2trg_q  <= 1'b0;
      sel_q    <= 6'h00;
      memlim_q <= u3mt_pkg::MEMLIM_RST;
      prelim_q <= u3mt_pkg::PRELIM_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        adv_q   <= hwdata[2];
        inf_q   <= hwdata[3];
        mode_q  <= hwdata[5:4];
        upg_q   <= hwdata[6];
        u2trg_q <= hwdata[7];
      end
      if (wr_sel)
        sel_q <= hwdata[5:0];
      if (wr_memlim)
        memlim_q <= (hwdata > u3mt_pkg::BUF_WORDS) ? u3mt_pkg::BUF_WORDS : hwdata;
      if (wr_prelim)
        prelim_q <= hwdata;
    end
  end

  // Config words are indexed {state, unit}; each state keeps its own copy.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 64; i++)
      begin
        cfg0_q[i] <= 32'h0;
        cfg1_q[i] <= 32'h0;
        cfg2_q[i] <= 32'h0;
        cfg3_q[i] <= 32'h0;
      end
    end
    else
    begin
      if (wr_cfg0)
        cfg0_q[sel_q] <= hwdata;
      if (wr_cfg1)
        cfg1_q[sel_q] <= hwdata;
      if (wr_cfg2)
        cfg2_q[sel_q] <= hwdata;
      if (wr_cfg3)
        cfg3_q[sel_q] <= hwdata;
    end
  end

  // -----------------------------------------------------------------
  // Match units
  // -----------------------------------------------------------------
  logic [2:0]  st_q;
  logic        entry_q;
  logic [15:0] cnt_q [0:5];
  logic [31:0] tmr_q;
  logic [5:0]  hit;
  logic [5:0]  fire;

  // Mode SS or both feeds SuperSpeed traffic to the units and the buffer.
  wire ss_on = (mode_q != u3mt_pkg::U3MT_MODE_HS);
  wire u2_on = (mode_q == u3mt_pkg::U3MT_MODE_HS) |
               ((mode_q == u3mt_pkg::U3MT_MODE_BOTH) & upg_q);
  wire pv    = pkt_valid & ss_on;

  genvar g;
  generate
    for (g = 0; g < u3mt_pkg::NU; g++)
    begin : g_unit
      wire [5:0]  idx = {st_q, 3'(g)};
      wire [31:0] c0  = cfg0_q[idx];
      wire [31:0] c1  = cfg1_q[idx];
      wire [31:0] c2  = cfg2_q[idx];
      wire [31:0] c3  = cfg3_q[idx];
      wire [15:0] cnt_nx = (cnt_q[g] == 16'hffff) ? cnt_q[g] : cnt_q[g] + 16'h1;
      wire [15:0] thr    = (c3[15:0] == 16'h0) ? 16'h1 : c3[15:0];
      if (g < u3mt_pkg::NDU)
      begin : g_data
        // CFG0: 0 en, 1 dir, 4:2 cat, 12:5 sub, 13 any sub, 14 invert,
        // 15 cross-category, 17:16 crc, 18 addr, 19 ep, 20 stream, 21 len.
        wire [2:0] ccat   = (c0[4:2] == u3mt_pkg::CAT_QDP) ? u3mt_pkg::CAT_DP : c0[4:2];
        wire       is_dp  = (ccat == u3mt_pkg::CAT_DP);
        wire       cat_eq = (pkt.cat == ccat);
        wire       scope  = (c0[4:2] == u3mt_pkg::CAT_QDP);
        wire       sc_ok  = ~scope |
                            ((~c0[18] | (pkt.addr == c2[6:0])) &
                             (~c0[19] | (pkt.ep == c2[10:7])) &
                             (~c0[20] | (pkt.strm == c1[31:16])) &
                             (~c0[21] | (pkt.len == c2[22:11])));
        wire       dp_ok  = (pkt.data == c1) & sc_ok;
        wire       sub_ok = is_dp ? (c0[13] | dp_ok)
                                  : (c0[13] | (pkt.sub == c0[12:5]));
        wire       pos    = cat_eq & sub_ok;
        wire       crit   = ~c0[14] ? pos
                          : (c0[15] ? ~pos : cat_eq & ~sub_ok);
        wire       crc_ok = (c0[17:16] == u3mt_pkg::CRC_ANY) |
                            ((c0[17:16] == u3mt_pkg::CRC_OK) & pkt.crc_ok) |
                            ((c0[17:16] == u3mt_pkg::CRC_BAD) & ~pkt.crc_ok);
        assign hit[g] = c0[0] & pv & (pkt.dir == c0[1]) & crit & crc_ok;
      end
      else if (g == u3mt_pkg::U_EV)
      begin : g_event
        // CFG0: 0 en, 11:1 event select mask.
        assign hit[g] = c0[0] & (|(ev_vec & c0[11:1]));
      end
      else
      begin : g_timer
        // CFG1 holds the interval in clock cycles (25 ns each).
        assign hit[g] = c0[0] & ~entry_q & (tmr_q == c1);
      end
      // CFG3: 15:0 count, 16 every, 17 trigger, 18 ext out, 19 filter,
      // 20 goto, 23:21 next state.
      assign fire[g] = hit[g] & (c3[16] ? (cnt_nx >= thr) : (cnt_nx == thr));

      always_ff @(posedge clk)
      begin
        if (!rst_n || entry_q)
          cnt_q[g] <= 16'h0;
        else if (hit[g])
          cnt_q[g] <= cnt_nx;
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Actions and state
  // -----------------------------------------------------------------
  logic       act_trig;
  logic       act_ext;
  logic       act_filt;
  logic       act_go;
  logic [2:0] go_st;

  always_comb
  begin
    act_trig = 1'b0;
    act_ext  = 1'b0;
    act_filt = 1'b0;
    act_go   = 1'b0;
    go_st    = 3'h0;
    for (int u = 0; u < u3mt_pkg::NU; u++)
    begin
      if (fire[u])
      begin
        act_trig = act_trig | cfg3_q[{st_q, 3'(u)}][17];
        act_ext  = act_ext | cfg3_q[{st_q, 3'(u)}][18];
        act_filt = act_filt | (cfg3_q[{st_q, 3'(u)}][19] & (u < u3mt_pkg::NDU));
      end
    end
    // Walk downward so the lowest-numbered goto wins.
    for (int u = u3mt_pkg::NU - 1; u >= 0; u--)
    begin
      if (fire[u] && cfg3_q[{st_q, 3'(u)}][20])
      begin
        act_go = adv_q;
        go_st  = cfg3_q[{st_q, 3'(u)}][23:21];
      end
    end
  end

  logic cap_q;
  logic trg_q;
  logic ext_q;
  logic trg_p_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n || start)
    begin
      st_q    <= 3'h0;
      entry_q <= 1'b1;
      tmr_q   <= 32'h0;
    end
    else if (act_go && cap_q)
    begin
      st_q    <= go_st;
      entry_q <= 1'b1;
      tmr_q   <= 32'h0;
    end
    else
    begin
      entry_q <= 1'b0;
      if (tmr_q != 32'hffff_ffff)
        tmr_q <= tmr_q + 32'h1;
    end
  end

  wire trg_req = cap_q & ~trg_q &
                 (act_trig | (u2trg_q & u2_on & (u2_hit | ext_rise)));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      trg_q   <= 1'b0;
      ext_q   <= 1'b0;
      trg_p_q <= 1'b0;
    end
    else
    begin
      trg_p_q <= trg_req;
      ext_q   <= cap_q & act_ext;
      if (start)
        trg_q <= 1'b0;
      else if (trg_req)
        trg_q <= 1'b1;
    end
  end

  assign trig_pulse = trg_p_q;
  assign ext_out    = ext_q;
  assign cur_state  = st_q;
  assign filt       = cap_q & act_filt;

  // -----------------------------------------------------------------
  // Capture buffer accounting and upload
  // -----------------------------------------------------------------
  logic [31:0] occ_q;
  logic [31:0] pre_q;
  logic [31:0] post_q;
  logic [31:0] stored_q;

  wire [31:0] post_lim = memlim_q - prelim_q;
  wire        full     = (occ_q >= u3mt_pkg::BUF_WORDS) |
                         (~inf_q & (occ_q >= memlim_q));
  wire        ss_w     = cap_q & pv & ~act_filt;
  wire        u2_w     = cap_q & u2_valid & u2_on;
  wire        wr_any   = (ss_w | u2_w) & ~full;
  // Before the trigger the pre region acts as a ring: oldest word drops.
  wire        ring     = ~trg_q & ~inf_q & (pre_q >= prelim_q) & wr_any;
  wire        drain    = upl_valid & upl_ready;
  wire        post_end = ~inf_q & trg_q & (post_q >= post_lim);

  assign store_ss  = ss_w & ~full;
  assign store_u2  = u2_w & ~full & ~ss_w;
  assign pre_drop  = ring;
  assign upl_valid = (occ_q != 32'h0);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cap_q    <= 1'b0;
      occ_q    <= 32'h0;
      pre_q    <= 32'h0;
      post_q   <= 32'h0;
      stored_q <= 32'h0;
    end
    else if (start)
    begin
      cap_q    <= 1'b1;
      pre_q    <= 32'h0;
      post_q   <= 32'h0;
      stored_q <= 32'h0;
    end
    else
    begin
      if (stop || post_end || (full && cap_q && (ss_w || u2_w)))
        cap_q <= 1'b0;
      if (wr_any)
        stored_q <= stored_q + 32'h1;
      if (wr_any && !ring && !trg_q)
        pre_q <= pre_q + 32'h1;
      if (wr_any && trg_q)
        post_q <= post_q + 32'h1;
      occ_q <= occ_q + ((wr_any && !ring) ? 32'h1 : 32'h0)
                     - ((drain && !(ring && occ_q == 32'h0)) ? 32'h1 : 32'h0);
    end
  end

  // -----------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------
  wire [31:0] stat_w = {24'h0, 1'b0, st_q, full, trg_q, cap_q, entry_q};

  always_comb
  begin
    hrdata = 32'h0;
    if (dp_rd_q)
    begin
      case (dp_addr_q)
        u3mt_pkg::A_CTRL:   hrdata = {24'h0, u2trg_q, upg_q, mode_q, inf_q, adv_q, 2'h0};
        u3mt_pkg::A_STAT:   hrdata = stat_w;
        u3mt_pkg::A_SEL:    hrdata = {26'h0, sel_q};
        u3mt_pkg::A_CFG0:   hrdata = cfg0_q[sel_q];
        u3mt_pkg::A_CFG1:   hrdata = cfg1_q[sel_q];
        u3mt_pkg::A_CFG2:   hrdata = cfg2_q[sel_q];
        u3mt_pkg::A_CFG3:   hrdata = cfg3_q[sel_q];
        u3mt_pkg::A_MEMLIM: hrdata = memlim_q;
        u3mt_pkg::A_PRELIM: hrdata = prelim_q;
        u3mt_pkg::A_OCC:    hrdata = occ_q;
        u3mt_pkg::A_STORED: hrdata = stored_q;
        default:            hrdata = 32'h0;
      endcase
    end
  end

endmodule

// ### test/test_usb3_match_action_trigger.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Bench
// -----------------------------------------------------------------
module test_usb3_match_action_trigger;
  logic                clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, rnd;
  logic                u2_valid, u2_hit, vbus_pin, ext_in_pin, upl_ready, upl_valid;
  logic                store_ss, store_u2, filt, trig_pulse, ext_out, pkt_valid, trg;
  logic [31:0]         haddr, hwdata, hrdata, q;
  logic [1:0]          htrans;
  logic [2:0]          hsize, cur_state, es;
  logic [15:0]         rs;
  u3mt_pkg::u3mt_pkt_t pkt, p;
  u3mt_pkg::u3mt_ev_t  ev;
  int                  err_count, checked, n, k, cnt[0:3];
  logic [31:0]         cf[0:3], c3[0:3];
  assign hready = hreadyout;
  u3mt_trigger uut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .pkt_valid, .pkt, .ev, .u2_valid, .u2_hit, .vbus_pin,
    .ext_in_pin, .upl_ready, .upl_valid, .store_ss, .store_u2, .pre_drop(), .filt,
    .trig_pulse, .ext_out, .cur_state);
  u3mt_link_model lnk (.pkt_valid, .pkt, .ev);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function logic [15:0] lf(input logic [15:0] s);
    lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wt;
    int i;
    i = 0;
    do
    begin
      // Read data is taken while it still stands, before the closing edge retires it.
      @(negedge clk);
      q = hrdata;
      @(posedge clk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      err_count++;
      end_of_test;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
  endtask
  task cfg(input int s, input int u, input logic [31:0] a0, a1, a3);
    bus(1'b1, u3mt_pkg::A_SEL, s * 8 + u);
    bus(1'b1, u3mt_pkg::A_CFG0, a0);
    bus(1'b1, u3mt_pkg::A_CFG1, a1);
    bus(1'b1, u3mt_pkg::A_CFG3, a3);
    if (s == 0 && u < 4)
    begin
      cf[u] = a0;
      c3[u] = a3;
    end
  endtask
  // The entry cycle counts no hits, so the first packet waits one edge.
  task start(input logic [31:0] c);
    bus(1'b1, u3mt_pkg::A_CTRL, c | 32'h1);
    cnt = '{default: 0};
    trg = 1'b0;
    @(posedge clk);
  endtask
  function bit hit(int u, u3mt_pkg::u3mt_pkt_t x);
    logic [31:0] c;
    bit          sc, sm;
    c   = cf[u];
    sc  = x.cat == c[4:2];
    sm  = sc && x.sub == c[12:5];
    hit = c[0] && x.dir == c[1] && (c[14] ? !sm && (sc || c[15]) : sm)
          && (c[17:16] == 2'h0 || x.crc_ok == (c[17:16] == 2'h1));
  endfunction
  task pk(input u3mt_pkg::u3mt_pkt_t x);
    bit f, t, e, fi;
    {f, t, e} = 3'h0;
    for (int u = 0; u < 4; u++)
      if (hit(u, x))
      begin
        cnt[u]++;
        fi = cnt[u] == c3[u][15:0] || (c3[u][16] && cnt[u] > c3[u][15:0]);
        f |= fi & c3[u][19];
        t |= fi & c3[u][17];
        e |= fi & c3[u][18];
      end
    lnk.send(1'b1, x, 8'h0);
    upl_ready <= rs[0] & rnd;
    #2 chk("filt", f, filt);
    @(posedge clk);
    lnk.rel;
    #2 chk("trig", t & !trg, trig_pulse);
    chk("ext", e, ext_out);
    chk("state", es, cur_state);
    trg |= t;
  endtask
  task run;
    for (n = 0; n < 40; n++)
    begin
      rs = lf(rs);
      k  = rs[2:1];
      p  = '0;
      p.dir = rs[3];
      p.crc_ok = rs[4];
      p.data = {rs, rs};
      p.cat = k == 0 ? u3mt_pkg::CAT_LC : k == 3 ? u3mt_pkg::CAT_TS : u3mt_pkg::CAT_HP;
      p.sub = k == 0 ? 8'h03 : k == 1 ? 8'h07 : k == 2 ? 8'h08 : 8'h01;
      pk(p);
    end
  endtask
  task drain;
    upl_ready <= 1'b1;
    for (n = 0; n < 600 && upl_valid !== 1'b0; n++)
      @(posedge clk);
    chk("drain", 0, upl_valid);
  endtask
  initial
  begin
    {hsel, hwrite, rst_n, u2_valid, u2_hit, vbus_pin, ext_in_pin, trg} = 8'h0;
    {haddr, hwdata, htrans, es, err_count, checked} = '0;
    hsize = 3'h2;
    upl_ready = 1'b1;
    rnd = 1'b1;
    rs = 16'h0040;
    cf = '{default: 0};
    c3 = '{default: 0};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, u3mt_pkg::A_MEMLIM, 0);
    chk("memlim", u3mt_pkg::MEMLIM_RST, q);
    bus(1'b0, u3mt_pkg::A_PRELIM, 0);
    chk("prelim", u3mt_pkg::PRELIM_RST, q);
    bus(1'b0, 8'h3c, 0);
    chk("unmapped", 0, q);
    bus(1'b1, u3mt_pkg::A_MEMLIM, 32'hffff_ffff);
    bus(1'b0, u3mt_pkg::A_MEMLIM, 0);
    chk("clamp", u3mt_pkg::BUF_WORDS, q);
    bus(1'b1, u3mt_pkg::A_MEMLIM, 32'h0000_0100);
    cfg(0, 0, 32'h0000_0061, 0, 32'h0002_0003);
    cfg(0, 1, 32'h0000_40e5, 0, 32'h0005_0001);
    cfg(0, 2, 32'h0002_0031, 0, 32'h0009_0002);
    start(0);
    run;
    cfg(0, 1, 32'h0000_c0e5, 0, 32'h0005_0001);
    start(0);
    run;
    p = '0;
    p.sub = 8'h03;
    p.crc_ok = 1'b1;
    cfg(0, 2, 0, 0, 0);
    cfg(0, 0, 32'h0000_0061, 0, 32'h00b0_0001);
    cfg(0, 1, 32'h0000_0061, 0, 32'h0050_0001);
    cfg(5, 5, 32'h1, 32'ha, 32'h0004_0001);
    start(0);
    pk(p);
    start(32'h4);
    es = 3'h5;
    pk(p);
    for (n = 0; n < 30 && ext_out !== 1'b1; n++)
      @(posedge clk) #2;
    chk("timer", 1, n >= 10 && n <= 14);
    cfg(0, 0, 0, 0, 0);
    cfg(0, 1, 0, 0, 0);
    es = 3'h0;
    start(0);
    for (k = 0; k < 11; k++)
    begin
      cfg(0, 4, 32'h1 | (32'h2 << k), 0, 32'h0005_0001);
      if (k < 8)
        lnk.send(1'b0, p, k < 4 ? 8'h10 << k : 8'h01 << (k - 4));
      else if (k == 8)
        vbus_pin <= 1'b1;
      else
        ext_in_pin <= k == 9;
      rnd = 1'b0;
      repeat (8)
      begin
        @(posedge clk);
        lnk.rel;
        #2 rnd |= ext_out;
      end
      chk("event", 1, rnd);
    end
    cfg(0, 4, 0, 0, 0);
    cfg(0, 0, 32'h0000_0061, 0, 32'h0002_0001);
    bus(1'b1, u3mt_pkg::A_MEMLIM, 32'h4);
    drain;
    rnd = 1'b0;
    upl_ready <= 1'b0;
    start(0);
    repeat (8) pk(p);
    bus(1'b0, u3mt_pkg::A_STAT, 0);
    chk("capturing", 0, q[1]);
    chk("upl", 1, upl_valid);
    bus(1'b0, u3mt_pkg::A_OCC, 0);
    chk("occ", 1, q > 0 && q <= 4);
    drain;
    start(32'h90);
    u2_hit <= 1'b1;
    @(posedge clk);
    u2_hit <= 1'b0;
    #2 chk("u2trig", 1, trig_pulse);
    end_of_test;
  end
endmodule

// ### test/u3mt_link_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Monitored link
// -----------------------------------------------------------------
module u3mt_link_model (
  output logic                pkt_valid,
  output u3mt_pkg::u3mt_pkt_t pkt,
  output u3mt_pkg::u3mt_ev_t  ev
);
  initial
  begin
    pkt_valid = 1'b0;
    pkt       = '0;
    ev        = '0;
  end
  task send(input logic v, input u3mt_pkg::u3mt_pkt_t p, input logic [7:0] e);
    pkt_valid <= v;
    pkt       <= p;
    ev        <= e;
  endtask
  // Idle fields flip so a stale packet can never pass for a fresh one.
  task rel;
    pkt_valid <= 1'b0;
    pkt       <= ~pkt;
    ev        <= '0;
  endtask
endmodule

// ### test/u3mt_trigger_asserts.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Port checker
// -----------------------------------------------------------------
module u3mt_trigger_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        pkt_valid,
  input wire logic        store_ss,
  input wire logic        store_u2,
  input wire logic        filt,
  input wire logic        trig_pulse,
  input wire logic        upl_valid,
  input wire logic [2:0]  cur_state
);
  logic wr_q;
  logic rd_q;
  logic adv_q;
  logic seen_q;
  wire  take = hsel && hready && htrans[1];
  wire  go   = wr_q && hwdata[0];
  // The advanced bit is mirrored so that a state move can be tied to it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      adv_q  <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      wr_q   <= take && hwrite && haddr[7:0] == u3mt_pkg::A_CTRL;
      rd_q   <= take && !hwrite;
      adv_q  <= wr_q ? hwdata[2] : adv_q;
      seen_q <= go ? 1'b0 : seen_q | trig_pulse;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence start_wr;
    wr_q && hwdata[0];
  endsequence
  sequence moved;
    cur_state != $past(cur_state) && cur_state != 3'h0;
  endsequence
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  idle_rdata_a: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  trig_once_a: assert property (trig_pulse |-> !seen_q)
    else $error("second trigger in one capture");
  single_state_a: assert property (moved |-> adv_q)
    else $error("state moved without advanced mode");
  filt_cause_a: assert property (filt |-> pkt_valid)
    else $error("filter without a packet");
  store_one_a: assert property (store_ss |-> pkt_valid && !store_u2)
    else $error("bad store source");
  upl_cause_a: assert property ($rose(upl_valid) |-> $past(store_ss || store_u2))
    else $error("upload data without a store");
  start_home_a: assert property (start_wr |=> cur_state == 3'h0)
    else $error("start did not return to state 0");
endmodule
bind u3mt_trigger u3mt_trigger_chk chk (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pkt_valid, .store_ss, .store_u2, .filt,
  .trig_pulse, .upl_valid, .cur_state);
